// ---- cds_pkg.sv ----
// Constants, field layout and carrier types for the completion
// descriptor status-field framer.
// Assumes a single user clock domain shared by all producers.
`default_nettype none

package cds_pkg;

  // Descriptor field positions
  localparam int CDS_DESC_W = 96;
  localparam int CDS_PKT_W = 128;
  localparam int CDS_ERR_LSB = 12;
  localparam int CDS_BC_LSB = 16;
  localparam int CDS_BC_W = 13;
  localparam int CDS_LOCK_BIT = 29;
  localparam int CDS_DONE_BIT = 30;
  localparam int CDS_FN_LSB = 48;
  localparam int CDS_TAG_LSB = 64;
  localparam int CDS_DUMMY_LSB = 96;
  localparam int CDS_ADDR_W = 7;

  // Fixed byte counts
  localparam logic [12:0] CDS_IO_BC = 13'h0004;
  localparam logic [12:0] CDS_ZL_BC = 13'h0001;

  // Register map (byte offsets) and reset values
  localparam logic [3:0] CDS_REG_CTRL = 4'h0;
  localparam logic [3:0] CDS_REG_STATUS = 4'h4;
  localparam logic [3:0] CDS_REG_ERRCNT = 4'h8;
  localparam logic [31:0] CDS_CTRL_RST = 32'h0000_0001;
  localparam int CDS_CTRL_CHK_BIT = 0;
  localparam int CDS_STAT_BUSY_BIT = 4;

  // Error codes; values outside this set are never produced
  typedef enum logic [3:0] {
    CDS_ERR_OK = 4'h0,
    CDS_ERR_POISON = 4'h1,
    CDS_ERR_STATUS = 4'h2,
    CDS_ERR_LEN = 4'h3,
    CDS_ERR_MISMATCH = 4'h4,
    CDS_ERR_ADDR = 4'h5,
    CDS_ERR_TAG = 4'h6,
    CDS_ERR_TIMEOUT = 4'h9
  } cds_err_t;

  // Request kinds
  typedef enum logic [1:0] {
    CDS_KIND_MEM = 2'h0,
    CDS_KIND_IORD = 2'h1,
    CDS_KIND_IOWR = 2'h2,
    CDS_KIND_MEM0 = 2'h3
  } cds_kind_t;

  // Request registered when a non-posted request is issued, unless a timeout or a table-updating completion is taken in that cycle
  typedef struct packed {
    logic [7:0] tag;
    logic [15:0] req_id;
    logic [2:0] tc;
    logic [2:0] attr;
    logic [12:0] total;
    logic [6:0] addr;
    cds_kind_t kind;
    logic locked;
  } cds_req_t;

  // Parsed completion header from the link side
  typedef struct packed {
    logic [7:0] tag;
    logic [15:0] req_id;
    logic [2:0] tc;
    logic [2:0] attr;
    logic [2:0] status;
    logic poison;
    logic [12:0] byte_count;
    logic [6:0] lower_addr;
    logic [12:0] bytes;
  } cds_cpl_t;

  // Outstanding request table entry
  typedef struct packed {
    logic busy;
    logic [15:0] req_id;
    logic [2:0] tc;
    logic [2:0] attr;
    logic [12:0] remain;
    logic [6:0] addr;
    cds_kind_t kind;
    logic locked;
  } cds_entry_t;

endpackage : cds_pkg

`default_nettype wire

// ---- cds_framer.sv ----
// Completion descriptor status-field framer: error code, byte count,
// locked-read and request-completed bits, emitted as a descriptor stream.
// Assumes request, completion and timeout inputs come from logic on mclk.
//
// Operation
// R01: Error code of completion checking sits in descriptor bits 15:12.
// R02: Normal end with all data received reports code 0000.
// R03: Poisoned completion reports code 0001.
// R04: UR, CA or CRS status ending a request reports code 0010.
// R05: No data, or byte count above expected, reports code 0011.
// R06: Known tag with wrong requester ID, TC or attributes reports 0100.
// R07: Low address differing from next expected byte reports 0101.
// R08: Tag matching no outstanding request reports 0110.
// R09: Timeout reports 1001; only bit 30, function and tag are valid.
// R10: Thirteen-bit byte count in bits 28:16, range 0 to 4096.
// R11: Single completion of memory read gives its payload size.
// R12: I/O read and write completions carry byte count 4.
// R13: Zero-length read gives byte count 1 plus one dummy dword.
// R14: Memory read byte count is bytes still needed, current ones included.
// R15: Next byte count is previous minus bytes previously returned.
// R16: Bit 29 set for locked read completions, clear otherwise.
// R17: Descriptor fills first 12 bytes: two 64-bit beats or one wide beat.
// R18: Bit 30 set in last completion of request, normal or error.
// R19: User logic reuses a tag only after a completed descriptor for it.
// R20: Reserved error code values are never driven.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`default_nettype none

module cds_framer
  import cds_pkg::*;
#(
  parameter int DW = 64,
  parameter int TAG_W = 5
) (
  input wire logic mclk, // User clock
  input wire logic arst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic req_valid, // New request
  input wire cds_req_t req_in, // Request parameters
  input wire logic cpl_valid, // Completion header valid
  input wire cds_cpl_t cpl_in, // Completion header
  output logic cpl_ready, // Completion taken
  input wire logic to_valid, // Timeout event
  input wire logic [7:0] to_tag, // Timed-out tag
  output logic to_ready, // Timeout taken
  output logic [DW-1:0] out_data, // Descriptor beat
  output logic out_valid, // Beat valid
  output logic out_last, // Last beat
  input wire logic out_ready // Consumer ready
);

  localparam int DEPTH = 1 << TAG_W;
  localparam int BEATS = (CDS_PKT_W + DW - 1) / DW;

  // Elaboration check on widths
  if (!(DW == 64 || DW == 128 || DW == 256) || TAG_W < 1 || TAG_W > 8) begin : g_chk
    $error("cds_framer: unsupported DW or TAG_W");
  end

  typedef enum logic {ST_IDLE, ST_SEND} cds_state_t;

  // Slice a descriptor beat from the packet
  function automatic logic [DW-1:0] beat_of(input logic [CDS_PKT_W-1:0] p);
    logic [CDS_PKT_W+DW-1:0] w;
    w = {{DW{1'b0}}, p};
    return w[DW-1:0];
  endfunction : beat_of

  ////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic rst_n = rst_s2_reg;

  ////////////////////////////////////////////////////////////////////
  // Outstanding request table
  cds_entry_t tbl [DEPTH];
  logic [DEPTH-1:0] busy_reg, busy_next;
  cds_entry_t ent;
  logic [TAG_W-1:0] ctag;
  logic tag_ok;
  logic cpl_go, to_go;
  logic chk_en;

  assign ctag = cpl_in.tag[TAG_W-1:0];
  assign ent = tbl[ctag];
  assign tag_ok = busy_reg[ctag] && (cpl_in.tag >> TAG_W) == 8'h00;

  // Check results for the offered completion
  cds_err_t err;
  logic [12:0] bc_out, remain_next;
  logic fin;
  always_comb begin
    remain_next = ent.remain - cpl_in.bytes; // R15
    fin = 1'b0;
    if (!tag_ok) begin
      err = CDS_ERR_TAG; // R08
    end else if (chk_en && (cpl_in.req_id != ent.req_id || cpl_in.tc != ent.tc
                            || cpl_in.attr != ent.attr)) begin
      err = CDS_ERR_MISMATCH; // R06
    end else if (cpl_in.poison) begin
      err = CDS_ERR_POISON; // R03
    end else if (cpl_in.status != 3'h0) begin
      err = CDS_ERR_STATUS; // R04
      fin = 1'b1;
    end else if (cpl_in.bytes == 13'h0000 && ent.kind == CDS_KIND_MEM
                 || cpl_in.byte_count > ent.remain
                 || cpl_in.bytes > ent.remain) begin
      err = CDS_ERR_LEN; // R05
      fin = 1'b1;
    end else if (chk_en && ent.kind == CDS_KIND_MEM
                 && cpl_in.lower_addr != ent.addr) begin
      err = CDS_ERR_ADDR; // R07
    end else begin
      err = CDS_ERR_OK; // R02
      fin = ent.kind != CDS_KIND_MEM || remain_next == 13'h0000;
    end
    // Byte count by request kind
    case (ent.kind)
      CDS_KIND_IORD, CDS_KIND_IOWR: bc_out = CDS_IO_BC; // R12
      CDS_KIND_MEM0: bc_out = CDS_ZL_BC; // R13
      default: bc_out = ent.remain; // R11 R14
    endcase
    if (!tag_ok) begin
      bc_out = cpl_in.byte_count;
    end
  end

  // Table update: request load, completion progress, retirement
  logic wr_en;
  logic [TAG_W-1:0] wr_idx;
  cds_entry_t wr_ent;
  always_comb begin
    busy_next = busy_reg;
    wr_en = 1'b0;
    wr_idx = req_in.tag[TAG_W-1:0];
    wr_ent = '0;
    if (to_go) begin
      busy_next[to_tag[TAG_W-1:0]] = 1'b0;
    end else if (cpl_go && tag_ok && err != CDS_ERR_MISMATCH) begin
      wr_en = 1'b1;
      wr_idx = ctag;
      wr_ent = ent;
      if (err == CDS_ERR_OK) begin
        wr_ent.remain = remain_next; // R15
        wr_ent.addr = ent.addr + cpl_in.bytes[6:0];
      end
      if (fin) begin
        busy_next[ctag] = 1'b0;
      end
    end else if (req_valid) begin
      wr_en = 1'b1;
      wr_ent.busy = 1'b1;
      wr_ent.req_id = req_in.req_id;
      wr_ent.tc = req_in.tc;
      wr_ent.attr = req_in.attr;
      wr_ent.kind = req_in.kind;
      wr_ent.locked = req_in.locked;
      wr_ent.addr = req_in.addr;
      wr_ent.remain = (req_in.kind == CDS_KIND_MEM) ? req_in.total : CDS_IO_BC;
      busy_next[wr_idx] = 1'b1;
    end
  end

  // Table registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= '0;
    end else if (ce) begin
      busy_reg <= busy_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      tbl[wr_idx] <= wr_ent;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Descriptor packet sequencer
  cds_state_t st_reg, st_next;
  logic [CDS_PKT_W-1:0] pkt_reg, pkt_next;
  logic [2:0] beat_reg, beat_next;
  logic [2:0] nbeat_reg, nbeat_next;
  logic [CDS_PKT_W-1:0] pkt_new;
  logic [2:0] nb_new;

  assign to_ready = st_reg == ST_IDLE;
  assign cpl_ready = st_reg == ST_IDLE && !to_valid;
  assign to_go = to_valid && to_ready;
  assign cpl_go = cpl_valid && cpl_ready;

  // Build the descriptor for the winning event
  always_comb begin
    pkt_new = '0;
    nb_new = 3'(BEATS);
    if (to_go) begin
      pkt_new[CDS_ERR_LSB +: 4] = CDS_ERR_TIMEOUT; // R09
      pkt_new[CDS_DONE_BIT] = 1'b1; // R09 R18
      pkt_new[CDS_FN_LSB +: 8] = tbl[to_tag[TAG_W-1:0]].req_id[7:0]; // R09
      pkt_new[CDS_TAG_LSB +: 8] = to_tag; // R09
    end else begin
      pkt_new[CDS_ERR_LSB +: 4] = err; // R01 R20
      pkt_new[CDS_BC_LSB +: CDS_BC_W] = bc_out; // R10
      pkt_new[CDS_LOCK_BIT] = tag_ok && ent.locked; // R16
      pkt_new[CDS_DONE_BIT] = tag_ok && fin; // R18
      pkt_new[CDS_FN_LSB +: 16] = cpl_in.req_id;
      pkt_new[CDS_TAG_LSB +: 8] = cpl_in.tag;
    end
    // 96-bit descriptor alone takes two 64-bit beats, the same as with dummy
    if (DW == 64 && !(to_go || (tag_ok && ent.kind == CDS_KIND_MEM0))) begin
      nb_new = 3'h2; // R17
    end else if (DW == 64) begin
      nb_new = 3'h2; // R13 R17
    end else begin
      nb_new = 3'h1; // R17
    end
  end

  // Sequencer next state
  always_comb begin
    st_next = st_reg;
    pkt_next = pkt_reg;
    beat_next = beat_reg;
    nbeat_next = nbeat_reg;
    case (st_reg)
      ST_IDLE: begin
        if (to_go || cpl_go) begin
          st_next = ST_SEND;
          pkt_next = pkt_new;
          beat_next = 3'h0;
          nbeat_next = nb_new;
        end
      end
      ST_SEND: begin
        if (out_ready) begin
          beat_next = beat_reg + 3'h1;
          pkt_next = CDS_PKT_W'(pkt_reg >> DW); // R17
          if (beat_next == nbeat_reg) begin
            st_next = ST_IDLE;
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      pkt_reg <= '0;
      beat_reg <= 3'h0;
      nbeat_reg <= 3'h0;
    end else if (ce) begin
      st_reg <= st_next;
      pkt_reg <= pkt_next;
      beat_reg <= beat_next;
      nbeat_reg <= nbeat_next;
    end
  end

  // Dummy dword for zero-length reads rides as zeros above bit 95
  assign out_data = beat_of(pkt_reg); // R13
  assign out_valid = st_reg == ST_SEND;
  assign out_last = st_reg == ST_SEND && beat_reg + 3'h1 == nbeat_reg;

  ////////////////////////////////////////////////////////////////////
  // Avalon-MM register slave
  logic [31:0] ctrl_reg, ctrl_next;
  logic [15:0] ecnt_reg, ecnt_next;
  logic [3:0] last_reg, last_next;
  logic ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic acc;

  assign acc = avs_read || avs_write;
  assign avs_waitrequest = acc && !ack_reg;
  assign avs_readdata = rd_reg;
  assign chk_en = ctrl_reg[CDS_CTRL_CHK_BIT];

  // Register next values
  always_comb begin
    ctrl_next = ctrl_reg;
    ecnt_next = ecnt_reg;
    last_next = last_reg;
    ack_next = acc && !ack_reg;
    rd_next = rd_reg;
    if (avs_write && ack_reg) begin
      if (avs_address == CDS_REG_CTRL && avs_byteenable[0]) begin
        ctrl_next[7:0] = avs_writedata[7:0] & 8'h01;
      end else if (avs_address == CDS_REG_ERRCNT) begin
        ecnt_next = 16'h0000;
      end
    end
    // Event after clear, so an error in the clearing cycle is still counted
    if (st_next == ST_SEND && st_reg == ST_IDLE) begin
      last_next = pkt_new[CDS_ERR_LSB +: 4];
      if (pkt_new[CDS_ERR_LSB +: 4] != CDS_ERR_OK) begin
        ecnt_next = ecnt_next + 16'h0001;
      end
    end
    if (avs_read && !ack_reg) begin
      case (avs_address)
        CDS_REG_CTRL: rd_next = ctrl_reg;
        CDS_REG_STATUS: rd_next = {27'h0000000, st_reg == ST_SEND, last_reg};
        CDS_REG_ERRCNT: rd_next = {16'h0000, ecnt_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CDS_CTRL_RST;
      ecnt_reg <= 16'h0000;
      last_reg <= 4'h0;
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      ecnt_reg <= ecnt_next;
      last_reg <= last_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end

endmodule : cds_framer

`default_nettype wire

// ---- cds_framer_asserts.sv ----
// Port checker for the descriptor framer: framing, codes, handshakes.
// Assumes DW=64, so every descriptor leaves as two beats.
`default_nettype none
module cds_framer_asserts
  import cds_pkg::*;
#(
  parameter int DW = 64,
  parameter int TAG_W = 5
) (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic avs_waitrequest, // Stall
  input wire logic cpl_valid, // Completion offer
  input wire logic cpl_ready, // Completion taken
  input wire logic to_valid, // Timeout offer
  input wire logic to_ready, // Timeout taken
  input wire logic [DW-1:0] out_data, // Beat
  input wire logic out_valid, // Beat valid
  input wire logic out_last, // Last beat
  input wire logic out_ready // Consumer ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Event taken, and first beat of a descriptor
  sequence s_take;
    (cpl_valid && cpl_ready) || (to_valid && to_ready);
  endsequence
  sequence s_head;
    out_valid && !out_last;
  endsequence
  sequence s_tail;
    out_valid && out_last;
  endsequence
  // Framing and field checks
  a_take_head: assert property (s_take |=> s_head)
    else $error("no first beat after event");
  a_two_beats: assert property (s_head and out_ready |=> s_tail)
    else $error("second beat missing");
  a_beat_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("beat changed while stalled");
  a_end_gap: assert property (s_tail and out_ready |=> !out_valid)
    else $error("beat after last");
  a_busy_stall: assert property (out_valid |-> !cpl_ready && !to_ready)
    else $error("input taken while sending");
  a_to_wins: assert property (to_valid |-> !cpl_ready)
    else $error("completion taken over timeout");
  a_to_code: assert property (to_valid && to_ready |=> out_data[15:12] == 4'h9 && out_data[30])
    else $error("timeout descriptor wrong");
  a_code_legal: assert property (s_head |-> out_data[15:12] inside {[4'h0:4'h6], 4'h9})
    else $error("reserved error code");
  a_bc_range: assert property (s_head |-> out_data[28:16] <= 13'h1000)
    else $error("byte count above range");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait too long");
endmodule : cds_framer_asserts

bind cds_framer cds_framer_asserts #(.DW(DW), .TAG_W(TAG_W)) u_chk (.mclk(mclk),
  .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready),
  .to_valid(to_valid), .to_ready(to_ready), .out_data(out_data), .out_valid(out_valid),
  .out_last(out_last), .out_ready(out_ready));
`default_nettype wire

// ---- cds_sink.sv ----
// Consumer model of the descriptor stream, prompt or stalling.
// Assumes DW=64: low beat first, last beat holds tag and dummy dword.
`default_nettype none
module cds_sink (
  input wire logic mclk, // Clock
  input wire logic slow, // Stall two of three cycles
  input wire logic [63:0] out_data, // Beat
  input wire logic out_valid, // Beat valid
  input wire logic out_last, // Last beat
  output logic out_ready = 1'b1, // Ready
  output logic [127:0] pkt = '0, // Descriptor and dummy dword
  output logic pkt_stb = 1'b0 // Packet complete
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  logic [63:0] lo = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Stall pattern and beat capture
  always @(posedge mclk) begin
    cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    out_ready <= !slow || cnt == 2'h2;
    pkt_stb <= 1'b0;
    if (out_valid && out_ready) begin
      if (!out_last) lo <= out_data;
      else begin
        pkt <= {out_data, lo};
        pkt_stb <= 1'b1;
      end
    end
  end
endmodule : cds_sink
`default_nettype wire

// ---- cds_framer_tb_top.sv ----
// Self-checking bench for the descriptor status-field framer.
// Assumes DW=64 and the stream consumer model beside the framer.
`default_nettype none
module cds_framer_tb_top;
  import cds_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, req_valid = 1'b0, cpl_valid = 1'b0, cpl_ready, to_valid = 1'b0;
  logic to_ready, out_valid, out_last, out_ready, slow = 1'b0, pkt_stb;
  cds_req_t req_in = '0;
  cds_cpl_t cpl_in = '0;
  logic [7:0] to_tag = 8'h0;
  logic [63:0] out_data;
  logic [127:0] pkt;
  logic [31:0] seed = 32'h6EC337EB;
  int error_cnt = 0, n_checks = 0, cyc = 0, chk_on = 1;
  int rem[32], adr[32], knd[32], lck[32], bsy[32], rid[32];
  always #5 mclk = ~mclk;
  cds_framer #(.DW(64), .TAG_W(5)) dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_in(req_in),
    .cpl_valid(cpl_valid), .cpl_in(cpl_in), .cpl_ready(cpl_ready), .to_valid(to_valid),
    .to_tag(to_tag), .to_ready(to_ready), .out_data(out_data), .out_valid(out_valid),
    .out_last(out_last), .out_ready(out_ready));
  cds_sink u_sink (.mclk(mclk), .slow(slow), .out_data(out_data), .out_valid(out_valid),
    .out_last(out_last), .out_ready(out_ready), .pkt(pkt), .pkt_stb(pkt_stb));
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bus access held until waitrequest is seen low
  task automatic avs(logic wr, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : avs
  task automatic req(int t, cds_kind_t k, int tot, int a, int l);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_in <= {8'(t), 16'(rid[t]), 3'h1, 3'h2, 13'(tot), 7'(a), k, 1'(l)};
    {bsy[t], rem[t], adr[t], knd[t], lck[t]} = {32'h0000_0001, tot, a, int'(k), l};
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask : req
  task automatic desc(int e, int bc, int lk, int dn, int t);
    int n = 0;
    while (pkt_stb !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("strobe", 1, pkt_stb);
    chk("code", e, pkt[15:12]);
    chk("done", dn, pkt[30]);
    chk("tag", t, pkt[71:64]);
    if (e != 9) chk("lock", lk, pkt[29]);
    if (e != 9) chk("count", bc, pkt[28:16]);
    if (e == 0 && bc == 1) chk("dummy", 0, pkt[127:96]);
  endtask : desc
  // Completion offer with its expected descriptor from the model
  task automatic cpl(int t, int bc, int by, int st = 0, int p = 0, int ra = -1, int la = -1);
    int e = 0, k = knd[t], b = bsy[t], r = rem[t], lk = bsy[t] ? lck[t] : 0, dn;
    if (!b) e = 6;
    else if (ra >= 0 && ra != rid[t] && chk_on) e = 4;
    else if (p) e = 1;
    else if (st) e = 2;
    else if (k == 0 && (by == 0 || bc > r || by > r)) e = 3;
    else if (k == 0 && la >= 0 && la != adr[t] && chk_on) e = 5;
    dn = e == 2 || e == 3 || (e == 0 && (k != 0 || r == by));
    @(posedge mclk);
    cpl_valid <= 1'b1;
    cpl_in <= {8'(t), ra < 0 ? 16'(rid[t]) : 16'(ra), 3'h1, 3'h2, 3'(st), 1'(p), 13'(bc),
      la < 0 ? 7'(adr[t]) : 7'(la), 13'(by)};
    do @(posedge mclk); while (cpl_ready !== 1'b1);
    cpl_valid <= 1'b0;
    if (e == 0 && k == 0) {rem[t], adr[t]} = {r - by, (adr[t] + by) % 128};
    if (dn) bsy[t] = 0;
    if (e != 6) bc = (k == 1 || k == 2) ? 4 : (k == 3) ? 1 : r;
    desc(e, bc, lk, dn, t);
  endtask : cpl
  task automatic tmo(int t);
    @(posedge mclk);
    to_valid <= 1'b1;
    to_tag <= 8'(t);
    do @(posedge mclk); while (to_ready !== 1'b1);
    to_valid <= 1'b0;
    bsy[t] = 0;
    desc(9, 0, 0, 1, t);
    chk("func", rid[t] & 32'h0000_00FF, pkt[55:48]);
  endtask : tmo
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] q;
    foreach (rid[i]) rid[i] = int'(rnd() & 32'h0000_FFFF);
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    avs(0, 4'h0, 0, q);
    chk("ctrl", 1, q);
    avs(1, 4'h0, 32'hFFFF_FFFE, q);
    avs(0, 4'h0, 0, q);
    chk("ctrl", 0, q);
    avs(1, 4'h0, 32'h1, q);
    avs(0, 4'hC, 0, q);
    chk("unmapped", 0, q);
    // Split read with poison, address and mismatch between parts, stray tag after the last
    req(1, CDS_KIND_MEM, 64, 16, 0);
    cpl(1, 64, 32);
    cpl(1, 32, 8, 0, 1);
    cpl(1, 32, 8, 0, 0, -1, 5);
    cpl(1, 32, 8, 0, 0, 16'h1234);
    cpl(1, 32, 32);
    cpl(1, 32, 32);
    slow <= 1'b1;
    req(2, CDS_KIND_MEM, 16, 0, 1);
    cpl(2, 16, 16);
    slow <= 1'b0;
    req(3, CDS_KIND_IORD, 4, 0, 0);
    cpl(3, 4, 4);
    req(4, CDS_KIND_IOWR, 4, 0, 0);
    cpl(4, 4, 0);
    req(5, CDS_KIND_MEM0, 1, 0, 0);
    cpl(5, 1, 4);
    for (int s = 1; s <= 4; s <<= 1) begin
      req(6, CDS_KIND_MEM, 8, 0, 0);
      cpl(6, 8, 8, s);
    end
    req(7, CDS_KIND_MEM, 8, 0, 0);
    cpl(7, 12, 12);
    req(8, CDS_KIND_MEM, 8, 0, 0);
    cpl(8, 8, 0);
    // Checks off: foreign ID and stray address pass as normal data
    avs(1, 4'h0, 0, q);
    chk_on = 0;
    req(10, CDS_KIND_MEM, 16, 8, 0);
    cpl(10, 16, 8, 0, 0, 16'h1234);
    cpl(10, 8, 8, 0, 0, -1, 3);
    avs(1, 4'h0, 32'h0000_0001, q);
    chk_on = 1;
    req(9, CDS_KIND_MEM, 8, 0, 0);
    tmo(9);
    avs(0, 4'h4, 0, q);
    chk("status", 9, 32'(q[3:0]));
    avs(0, 4'h8, 0, q);
    chk("errcnt", 10, 32'(q[15:0]));
    avs(1, 4'h8, 0, q);
    avs(0, 4'h8, 0, q);
    chk("errcnt", 0, 32'(q[15:0]));
    print_verdict();
  end
endmodule : cds_framer_tb_top
`default_nettype wire
